// File: design/rle_pipe_pkg.sv
// constants shared by the run-length data pipeline
`default_nettype none
package rle_pipe_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int TICK_PERIOD_NS = 1000;
  localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] TICK_LAST = 6'(TICK_CYCLES - 1);
  localparam logic [5:0] TICK_ZERO = 6'h00;
  localparam logic [5:0] TICK_STEP = 6'h01;
  localparam int BYTE_W = 8;
  localparam int ENTRY_W = 9;
  localparam int BUF_DEPTH = 2;
  localparam logic [6:0] RUN_ZERO = 7'h00;
  localparam logic [6:0] RUN_ONE = 7'h01;
  localparam logic [6:0] RUN_MAX = 7'h7F;
  localparam logic [7:0] STALE_ZERO = 8'h00;
  localparam logic [7:0] STALE_STEP = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic DIR_RX = 1'b0;
  localparam int STAT_TIMEOUT = 5;
  localparam int STAT_STALE = 2;
  localparam int STAT_SINGLE = 1;
  localparam int STAT_EMPTY = 0;
  localparam int HOLD_FIRST_FULL = 0;
  localparam int HOLD_FIRST_TAG = 1;
  localparam int HOLD_SECOND_FULL = 2;
  localparam int HOLD_SECOND_TAG = 3;
  typedef enum {EMIT_NORMAL, EMIT_CHAR_DUE} emit_state_type;
endpackage
`default_nettype wire

// File: design/rle_pipe_if.sv
// interfaces between the pipeline and its timer and buffer
`default_nettype none
interface stale_link_if;
  logic reload;
  logic cpu_write;
  logic suppress;
  logic stale;
  logic [7:0] preset;
  logic [7:0] cpu_data;
  modport timer (input reload, cpu_write, suppress, preset, cpu_data, output stale);
  modport pipe (output reload, cpu_write, suppress, preset, cpu_data, input stale);
endinterface // stale_link_if

interface entry_stream_if;
  logic valid;
  logic ready;
  logic [rle_pipe_pkg::ENTRY_W-1:0] data;
  modport src (output valid, data, input ready);
  modport snk (input valid, data, output ready);
endinterface // entry_stream_if
`default_nettype wire

// File: design/stale_timer.sv
// stale-data down counter with its timebase divider
`default_nettype none
module stale_timer
(
  input wire logic clk_i,
  input wire logic rst_i,
  stale_link_if.timer lnk
);
  import rle_pipe_pkg::*;
  logic [5:0] tick_cnt_reg;
  logic [7:0] count_reg;
  logic tick;

  assign tick = tick_cnt_reg == TICK_LAST;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick)
      tick_cnt_reg <= TICK_ZERO;
    else
      tick_cnt_reg <= tick_cnt_reg + TICK_STEP;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= STALE_ZERO;
    else if (lnk.cpu_write)
      count_reg <= lnk.cpu_data;
    else if (lnk.reload)
      count_reg <= lnk.preset;
    else if (tick && count_reg != STALE_ZERO)
      count_reg <= count_reg - STALE_STEP;
  end

  // suppression masks the flag only; the counter itself still sits at zero
  assign lnk.stale = (count_reg == STALE_ZERO) && !lnk.suppress;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_stale_reload: assert property (lnk.reload && !lnk.cpu_write |=> count_reg == $past(lnk.preset))
    else $error("timer did not reload from preset");
  a_stale_suppress: assert property (lnk.suppress |-> !lnk.stale)
    else $error("stale shown while suppressed");
  a_count_floor: assert property (count_reg == STALE_ZERO && !lnk.reload && !lnk.cpu_write |=> count_reg == STALE_ZERO)
    else $error("timer left zero without a load");
endmodule // stale_timer
`default_nettype wire

// File: design/two_entry_buffer.sv
// two-entry buffer between the transmit pipeline and the fifo
`default_nettype none
module two_entry_buffer
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  entry_stream_if.snk in_s,
  entry_stream_if.src out_s
);
  import rle_pipe_pkg::*;
  logic [ENTRY_W-1:0] mem [BUF_DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_s.ready = count_reg != 2'(BUF_DEPTH);
  assign out_s.valid = count_reg != 2'h0;
  assign out_s.data = mem[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  always_ff @(posedge clk_i)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_s.data;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      count_reg <= count_reg + 2'(push) - 2'(pop);
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_full_refuse: assert property (count_reg == 2'(BUF_DEPTH) |-> !in_s.ready && out_s.valid)
    else $error("full buffer still accepting");
endmodule // two_entry_buffer
`default_nettype wire

// File: design/rle_data_pipeline.sv
// holding pipeline with run-length coding between the fifo and the word buffer
`default_nettype none
// What this block does
// - direction bit 0 receive, 1 transmit
// - tagged run count loads counter, not stage
// - hold first stage, copy forward, decrement
// - address or uncompressed tags interrupt
// - retained count expands next byte
// - timer reloads on every fifo byte in receive only
// - zero count sets stale unless suppressed
// - stale with two bytes requests dma
// - stale with one byte flags and interrupts
// - never move an odd byte by dma
// - single residual latches, halts until read
// - new fifo bytes clear empty flag in receive only
// - timeout latched, cleared by reset bits
// - pipeline interrupts gated by enables, except tagged
// - receive timeout waits for drained pipeline
// - writing counter one arms a timer
// - uncompressed transmit flows straight through
// - three equal bytes start a run
// - run ends at break or 127
// - release flushes held stages to fifo
// - transmit timeout sets on stale rise
module rle_data_pipeline
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic transfer_direction_bit_i,
  input wire logic compression_enable_i,
  input wire logic dma_transfer_enable_i,
  input wire logic direct_buffer_write_enable_i,
  input wire logic stale_suppress_i,
  input wire logic fifo_reset_bit_i,
  input wire logic clear_timeout_bit_i,
  input wire logic timeout_int_enable_i,
  input wire logic single_int_enable_i,
  input wire logic data_error_int_enable_i,
  input wire logic data_error_flag_i,
  input wire logic byte_swap_i,
  input wire logic [7:0] stale_timer_preset_i,
  input wire logic stale_counter_write_i,
  input wire logic [7:0] stale_counter_data_i,
  input wire logic fifo_put_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_tag_i,
  input wire logic host_acknowledge_line_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_tag_o,
  input wire logic tx_ready_i,
  input wire logic word_write_i,
  input wire logic [15:0] word_write_data_i,
  input wire logic word_read_i,
  output logic [15:0] word_data_o,
  output logic word_valid_o,
  output logic dma_request_o,
  input wire logic first_stage_read_i,
  input wire logic second_stage_read_i,
  output logic [7:0] first_stage_data_o,
  output logic [7:0] second_stage_data_o,
  output logic [3:0] holding_status_o,
  output logic [7:0] fifo_status_o,
  output logic [6:0] run_counter_o,
  output logic tagged_int_o,
  output logic pipeline_int_o
);
  import rle_pipe_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic s1_v_reg, s1_t_reg, s2_v_reg, s2_t_reg;
  logic [7:0] s1_d_reg, s2_d_reg;
  logic [6:0] rc_reg;
  logic [15:0] word_reg;
  logic word_v_reg, byte_idx_reg;
  logic single_reg, timeout_reg, trig_reg, stale_d_reg;
  emit_state_type emit_state_reg;
  logic rx, clr, stale, stale_rise, copying, rx_is_count, rx_pop, pair_go, shift_go, rx_done;
  logic in_v, release_hold, full3, start, cont, push_count, push_char, tx_s2_take, tx_s1_take;
  logic [7:0] in_d;

  stale_link_if lnk ();
  entry_stream_if buf_in ();
  entry_stream_if buf_out ();

  assign rx = transfer_direction_bit_i == DIR_RX;
  assign clr = fifo_reset_bit_i;
  assign copying = rc_reg != RUN_ZERO;

  // ----------------------------------------
  // receive steering
  // ----------------------------------------
  assign rx_ready_o = rx && !s1_v_reg && !single_reg;
  assign rx_pop = rx_ready_o && rx_valid_i;
  assign rx_is_count = rx_tag_i && host_acknowledge_line_i && compression_enable_i;
  // tagged bytes never pair into a word, so they stay visible to the cpu
  assign pair_go = rx && s1_v_reg && s2_v_reg && !s1_t_reg && !s2_t_reg && !word_v_reg && !single_reg;
  assign shift_go = rx && s1_v_reg && !s2_v_reg && !single_reg;
  assign rx_done = !word_v_reg && !rx_valid_i && !(s1_v_reg && s2_v_reg);

  // ----------------------------------------
  // transmit steering
  // ----------------------------------------
  assign in_v = !rx && word_v_reg;
  assign in_d = (byte_idx_reg ^ byte_swap_i) ? word_reg[15:8] : word_reg[7:0];
  assign release_hold = !compression_enable_i || (!dma_transfer_enable_i && !direct_buffer_write_enable_i);
  assign full3 = s1_v_reg && s2_v_reg && in_v;
  assign start = !rx && emit_state_reg == EMIT_NORMAL && !copying && !release_hold && full3
                 && s2_d_reg == s1_d_reg && s1_d_reg == in_d;
  assign cont = !rx && copying && !release_hold && full3 && in_d == s1_d_reg && rc_reg != RUN_MAX;
  assign push_count = !rx && copying && s2_v_reg && buf_in.ready && (release_hold || (full3 && !cont));
  // with compression on and no release, a byte leaves after its run count or when a full pipe proves no run starts
  assign push_char = !rx && s2_v_reg && buf_in.ready && (emit_state_reg == EMIT_CHAR_DUE
                     || (!copying && (release_hold || (s1_v_reg && in_v && !start))));
  assign tx_s2_take = !rx && s1_v_reg && (start || (!copying && (push_char || !s2_v_reg)));
  assign tx_s1_take = in_v && (!s1_v_reg || tx_s2_take || cont);

  assign buf_in.valid = push_count || push_char;
  assign buf_in.data = push_count ? {1'b1, 1'b0, rc_reg} : {1'b0, s2_d_reg};
  assign buf_out.ready = tx_ready_i;
  assign tx_valid_o = buf_out.valid;
  assign tx_data_o = buf_out.data[BYTE_W-1:0];
  assign tx_tag_o = buf_out.data[ENTRY_W-1];

  two_entry_buffer u_buffer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_i(clr),
    .in_s(buf_in),
    .out_s(buf_out)
  );

  // ----------------------------------------
  // holding stages
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr)
    begin
      s1_v_reg <= 1'b0;
      s1_t_reg <= 1'b0;
      s1_d_reg <= BYTE_ZERO;
    end
    else if (rx_pop && !rx_is_count)
    begin
      s1_v_reg <= 1'b1;
      s1_t_reg <= rx_tag_i;
      s1_d_reg <= rx_data_i;
    end
    else if (tx_s1_take)
    begin
      s1_v_reg <= 1'b1;
      s1_t_reg <= 1'b0;
      s1_d_reg <= in_d;
    end
    else if (first_stage_read_i || ((pair_go || shift_go) && !copying) || tx_s2_take)
      s1_v_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr)
    begin
      s2_v_reg <= 1'b0;
      s2_t_reg <= 1'b0;
      s2_d_reg <= BYTE_ZERO;
    end
    else if (shift_go || tx_s2_take)
    begin
      s2_v_reg <= 1'b1;
      s2_t_reg <= s1_t_reg && rx;
      s2_d_reg <= s1_d_reg;
    end
    else if (pair_go || push_char || second_stage_read_i)
      s2_v_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr)
      rc_reg <= RUN_ZERO;
    else if (rx_pop && rx_is_count)
      rc_reg <= rx_data_i[6:0];
    else if (copying && (pair_go || shift_go))
      rc_reg <= rc_reg - RUN_ONE;
    else if (start)
      rc_reg <= RUN_ONE;
    else if (cont)
      rc_reg <= rc_reg + RUN_ONE;
    else if (push_count)
      rc_reg <= RUN_ZERO;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr)
      emit_state_reg <= EMIT_NORMAL;
    else
      case (emit_state_reg)
        EMIT_NORMAL: if (push_count) emit_state_reg <= EMIT_CHAR_DUE;
        EMIT_CHAR_DUE: if (push_char) emit_state_reg <= EMIT_NORMAL;
        default: emit_state_reg <= EMIT_NORMAL;
      endcase
  end

  // ----------------------------------------
  // word buffer
  // ----------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr)
    begin
      word_v_reg <= 1'b0;
      byte_idx_reg <= 1'b0;
      word_reg <= WORD_ZERO;
    end
    else if (pair_go)
    begin
      word_v_reg <= 1'b1;
      word_reg <= byte_swap_i ? {s2_d_reg, s1_d_reg} : {s1_d_reg, s2_d_reg};
    end
    else if (!rx && word_write_i && !word_v_reg)
    begin
      word_v_reg <= 1'b1;
      byte_idx_reg <= 1'b0;
      word_reg <= word_write_data_i;
    end
    else if (rx && word_read_i)
      word_v_reg <= 1'b0;
    else if (tx_s1_take)
    begin
      word_v_reg <= !byte_idx_reg;
      byte_idx_reg <= !byte_idx_reg;
    end
  end

  assign word_data_o = word_reg;
  assign word_valid_o = word_v_reg;
  assign dma_request_o = dma_transfer_enable_i && (rx ? word_v_reg : !word_v_reg);

  // ----------------------------------------
  // stale timer, single residual and timeout
  // ----------------------------------------
  assign lnk.reload = rx && fifo_put_i;
  assign lnk.cpu_write = stale_counter_write_i;
  assign lnk.cpu_data = stale_counter_data_i;
  assign lnk.preset = stale_timer_preset_i;
  assign lnk.suppress = stale_suppress_i;
  assign stale = lnk.stale;
  assign stale_rise = stale && !stale_d_reg && !clear_timeout_bit_i && !clr;

  stale_timer u_timer
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lnk(lnk)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      stale_d_reg <= 1'b1;
    else
      stale_d_reg <= stale;
  end

  // the cpu read is what drains the residual byte, so it outranks a new latch
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr || second_stage_read_i)
      single_reg <= 1'b0;
    else if (rx && stale && !rx_valid_i && !word_v_reg && s2_v_reg && !s1_v_reg && !copying)
      single_reg <= 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr || clear_timeout_bit_i)
      trig_reg <= 1'b0;
    else if (rx && stale_rise)
      trig_reg <= 1'b1;
    else if (timeout_reg)
      trig_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clr || clear_timeout_bit_i)
      timeout_reg <= 1'b0;
    else if ((!rx && stale_rise) || (rx && trig_reg && rx_done))
      timeout_reg <= 1'b1;
  end

  // ----------------------------------------
  // status and interrupts
  // ----------------------------------------
  always_comb
  begin
    fifo_status_o = 8'h00;
    fifo_status_o[STAT_TIMEOUT] = timeout_reg;
    fifo_status_o[STAT_STALE] = stale;
    fifo_status_o[STAT_SINGLE] = single_reg;
    fifo_status_o[STAT_EMPTY] = !(rx && rx_valid_i);
    holding_status_o = 4'h0;
    holding_status_o[HOLD_FIRST_FULL] = s1_v_reg;
    holding_status_o[HOLD_FIRST_TAG] = s1_t_reg;
    holding_status_o[HOLD_SECOND_FULL] = s2_v_reg;
    holding_status_o[HOLD_SECOND_TAG] = s2_t_reg;
  end

  assign first_stage_data_o = s1_d_reg;
  assign second_stage_data_o = s2_d_reg;
  assign run_counter_o = rc_reg;
  assign tagged_int_o = rx && ((s1_v_reg && s1_t_reg) || (s2_v_reg && s2_t_reg));
  assign pipeline_int_o = (timeout_reg && timeout_int_enable_i) || (single_reg && single_int_enable_i)
                          || (data_error_flag_i && data_error_int_enable_i) || tagged_int_o;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence count_then_char;
    (emit_state_reg == EMIT_CHAR_DUE && rc_reg == RUN_ZERO) ##[0:20] push_char;
  endsequence
  a_count_load: assert property (rx_pop && rx_is_count && !clr |=>
                                 {1'b0, rc_reg} == ($past(rx_data_i) & 8'h7F) && !s1_v_reg)
    else $error("run count not loaded into counter");
  a_copy_hold: assert property (shift_go && copying && !clr |=>
                                s1_v_reg && s2_d_reg == s1_d_reg && rc_reg == $past(rc_reg) - RUN_ONE)
    else $error("decompression copy wrong");
  a_tag_irq: assert property (rx && s2_v_reg && s2_t_reg |-> tagged_int_o && pipeline_int_o && !pair_go)
    else $error("tagged byte without interrupt");
  a_single_halt: assert property (single_reg |-> !rx_ready_o && !pair_go && !shift_go)
    else $error("pipeline moved while residual latched");
  a_empty_flag: assert property (rx && rx_valid_i |-> !fifo_status_o[STAT_EMPTY])
    else $error("empty shown with fifo data");
  a_timeout_clear: assert property (clear_timeout_bit_i || clr |=> !timeout_reg)
    else $error("timeout not cleared");
  a_tx_timeout: assert property (!rx && stale_rise |=> timeout_reg)
    else $error("transmit timeout not immediate");
  a_run_start: assert property (start && !clr |-> !buf_in.valid ##1 rc_reg == RUN_ONE)
    else $error("run start not counted");
  a_run_emit: assert property (push_count && !clr |-> buf_in.data[ENTRY_W-1] ##1 count_then_char)
    else $error("run count not followed by character");
endmodule // rle_data_pipeline
`default_nettype wire

// File: test/dma_host_model.sv
// dma controller model serving the word buffer
`default_nettype none
module dma_host_model
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic dir_i,
  input wire logic slow_i,
  input wire logic dma_request_i,
  input wire logic word_valid_i,
  output logic word_read_o,
  output logic word_write_o,
  output logic [15:0] word_data_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] tx_q[$];
  int gap = 0;
  task automatic push_word(input logic [15:0] w);
    tx_q.push_back(w);
  endtask
  initial word_read_o = 1'b0;
  initial word_write_o = 1'b0;
  initial word_data_o = 16'h0000;
  // one word per request, held to the taking edge; released data inverted
  always @(negedge clk_i)
  begin
    if (word_read_o || word_write_o)
    begin
      word_read_o <= 1'b0;
      word_write_o <= 1'b0;
      word_data_o <= ~word_data_o;
    end
    else if (gap > 0)
      gap <= gap - 1;
    else if (!rst_i && dma_request_i && !dir_i && word_valid_i)
    begin
      word_read_o <= 1'b1;
      gap <= slow_i ? 6 : 0;
    end
    else if (!rst_i && dma_request_i && dir_i && !word_valid_i && tx_q.size() > 0)
    begin
      word_write_o <= 1'b1;
      word_data_o <= tx_q.pop_front();
      gap <= slow_i ? 6 : 0;
    end
  end
endmodule // dma_host_model
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the run-length data pipeline
`default_nettype none
module tb_top;
  import rle_pipe_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  // ----
  // stimulus and observed signals
  // ----
  logic clk_i = 1'b0, rst_i = 1'b1, dir = 1'b0, comp = 1'b0, dma_en = 1'b1, frst = 1'b0, clr_to = 1'b0;
  logic to_en = 1'b1, one_en = 1'b1, err_en = 1'b0, err = 1'b0, swap = 1'b1, cnt_wr = 1'b0, put = 1'b0;
  logic rx_valid = 1'b0, rx_tag = 1'b0, ack = 1'b0, tx_ready = 1'b1, rd1 = 1'b0, rd2 = 1'b0, slow = 1'b0;
  logic [7:0] rx_data = 8'h00, tx_data, st1, st2, fsr, prev_b, last_b;
  logic rx_ready, tx_valid, tx_tag, word_wr, word_rd, word_valid, dma_req, tag_int, pipe_int;
  logic [15:0] word_wdata, word_data;
  logic [3:0] hold;
  logic [6:0] run_cnt;
  logic [31:0] lfsr = 32'hDBC88E54;
  logic sup = 1'b0;
  logic [9:0] rx_q[$];
  logic [15:0] exp_words[$];
  logic [8:0] exp_bytes[$];
  int fails = 0, checked = 0, fed = 0;
  always #12.5 clk_i = ~clk_i;
  rle_data_pipeline dut (.clk_i(clk_i), .rst_i(rst_i), .transfer_direction_bit_i(dir),
    .compression_enable_i(comp), .dma_transfer_enable_i(dma_en), .direct_buffer_write_enable_i(1'b0),
    .stale_suppress_i(sup), .fifo_reset_bit_i(frst), .clear_timeout_bit_i(clr_to),
    .timeout_int_enable_i(to_en), .single_int_enable_i(one_en), .data_error_int_enable_i(err_en),
    .data_error_flag_i(err), .byte_swap_i(swap), .stale_timer_preset_i(8'h03),
    .stale_counter_write_i(cnt_wr), .stale_counter_data_i(8'h01), .fifo_put_i(put), .rx_valid_i(rx_valid),
    .rx_data_i(rx_data), .rx_tag_i(rx_tag), .host_acknowledge_line_i(ack), .rx_ready_o(rx_ready),
    .tx_valid_o(tx_valid), .tx_data_o(tx_data), .tx_tag_o(tx_tag), .tx_ready_i(tx_ready),
    .word_write_i(word_wr), .word_write_data_i(word_wdata), .word_read_i(word_rd), .word_data_o(word_data),
    .word_valid_o(word_valid), .dma_request_o(dma_req), .first_stage_read_i(rd1), .second_stage_read_i(rd2),
    .first_stage_data_o(st1), .second_stage_data_o(st2), .holding_status_o(hold), .fifo_status_o(fsr),
    .run_counter_o(run_cnt), .tagged_int_o(tag_int), .pipeline_int_o(pipe_int));
  dma_host_model host (.clk_i(clk_i), .rst_i(rst_i), .dir_i(dir), .slow_i(slow), .dma_request_i(dma_req),
    .word_valid_i(word_valid), .word_read_o(word_rd), .word_write_o(word_wr), .word_data_o(word_wdata));
  // ----
  // checking and driving tasks
  // ----
  task automatic give_verdict();
    $display("fails=%0d checked=%0d", fails, checked);
    if (fails == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic note(input string m);
    fails++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask
  task automatic cmp_bit(input logic e, input logic g);
    checked++;
    if (g !== e)
      note("flag mismatch");
  endtask
  task automatic cmp_byte(input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e)
      note($sformatf("byte exp %h got %h", e, g));
  endtask
  task automatic cmp_word(input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
      note($sformatf("word exp %h got %h", e, g));
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cycles(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  // sel below 8 picks a status bit, 8 the tag interrupt, 9 all results seen
  task automatic wait_on(input int sel, input logic v);
    int n;
    n = 0;
    while (((sel < 8) ? fsr[sel] : (sel == 8) ? tag_int : (exp_words.size() + exp_bytes.size() == 0)) !== v)
    begin
      @(negedge clk_i);
      n++;
      if (n > 3000)
      begin
        note("wait timed out");
        give_verdict();
      end
    end
  endtask
  task automatic rx_pair(input logic [7:0] a, input logic [7:0] b);
    exp_words.push_back(swap ? {a, b} : {b, a});
  endtask
  task automatic put_rx(input logic t, input logic a, input logic [7:0] d);
    rx_q.push_back({t, a, d});
    pulse(put);
  endtask
  task automatic feed(input int n);
    repeat (n)
    begin
      lfsr = lfsr_next(lfsr);
      last_b = lfsr[7:0];
      if (fed[0])
        rx_pair(prev_b, last_b);
      prev_b = last_b;
      fed++;
      put_rx(1'b0, 1'b0, last_b);
    end
  endtask
  task automatic tx_word(input logic [7:0] a, input logic [7:0] b, input logic plain);
    host.push_word(swap ? {a, b} : {b, a});
    if (plain)
    begin
      exp_bytes.push_back({1'b0, a});
      exp_bytes.push_back({1'b0, b});
    end
  endtask
  task automatic clean();
    pulse(frst);
    fed = 0;
  endtask
  // fifo head and receiver stalls; an empty fifo shows a changing pattern
  always @(posedge clk_i)
    if (rx_valid && rx_ready)
      void'(rx_q.pop_front());
  always @(negedge clk_i)
  begin
    #1;
    rx_valid = rx_q.size() > 0;
    {rx_tag, ack, rx_data} = (rx_q.size() > 0) ? rx_q[0] : ~{rx_tag, ack, rx_data};
    lfsr = lfsr_next(lfsr);
    tx_ready = lfsr[3] | lfsr[9];
  end
  always @(posedge clk_i)
    if (!rst_i)
    begin
      if (word_rd && word_valid && !dir)
      begin
        if (exp_words.size() == 0)
          note("word not expected");
        else
          cmp_word(exp_words.pop_front(), word_data);
      end
      if (tx_valid && tx_ready && dir)
      begin
        if (exp_bytes.size() == 0)
          note("byte not expected");
        else
          cmp_byte(exp_bytes.pop_front(), {tx_tag, tx_data});
      end
    end
  // ----
  // main sequence
  // ----
  initial
  begin
    logic [7:0] a;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    cmp_byte(9'h000, {2'b00, run_cnt});
    cmp_byte(9'h000, {5'h00, hold});
    cmp_bit(1'b0, fsr[STAT_TIMEOUT]);
    cmp_bit(1'b1, fsr[STAT_STALE]);
    cycles(1);
    cmp_bit(1'b0, fsr[STAT_TIMEOUT]);
    for (int s = 0; s < 2; s++)
    begin
      swap = s[0];
      slow = s[0];
      feed(6);
      wait_on(9, 1'b1);
    end
    clean();
    feed(3);
    cmp_bit(1'b0, fsr[STAT_STALE]);
    wait_on(STAT_SINGLE, 1'b1);
    cmp_bit(1'b0, dma_req);
    wait_on(STAT_TIMEOUT, 1'b1);
    cmp_bit(1'b1, fsr[STAT_STALE]);
    cmp_byte({1'b0, last_b}, {1'b0, st2});
    cmp_bit(1'b1, pipe_int);
    one_en = 1'b0;
    to_en = 1'b0;
    cycles(1);
    cmp_bit(1'b0, pipe_int);
    one_en = 1'b1;
    to_en = 1'b1;
    a = last_b;
    fed = 0;
    feed(1);
    cmp_bit(1'b0, fsr[STAT_EMPTY]);
    cmp_byte({1'b0, a}, {1'b0, st2});
    pulse(rd2);
    pulse(clr_to);
    cmp_bit(1'b0, fsr[STAT_TIMEOUT]);
    feed(1);
    wait_on(9, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      clean();
      comp = k[0];
      lfsr = lfsr_next(lfsr);
      a = lfsr[7:0];
      put_rx(1'b1, ~k[0], a);
      wait_on(8, 1'b1);
      cycles(1);
      cmp_bit(1'b1, hold[HOLD_FIRST_TAG] | hold[HOLD_SECOND_TAG]);
      cmp_byte({1'b0, a}, {1'b0, hold[HOLD_SECOND_TAG] ? st2 : st1});
      if (hold[HOLD_SECOND_TAG])
        pulse(rd2);
      else
        pulse(rd1);
      cycles(1);
      cmp_bit(1'b0, tag_int);
    end
    clean();
    for (int r = 1; r < 4; r += 2)
    begin
      lfsr = lfsr_next(lfsr);
      a = lfsr[7:0];
      put_rx(1'b1, 1'b1, 8'h01);
      cycles(8);
      cmp_byte(9'h001, {2'b00, run_cnt});
      put_rx(1'b1, 1'b1, 8'h03);
      cycles(8 * r);
      cmp_byte(9'h003, {2'b00, run_cnt});
      rx_pair(a, a);
      rx_pair(a, a);
      put_rx(1'b0, 1'b0, a);
      wait_on(9, 1'b1);
    end
    dir = 1'b1;
    for (int m = 0; m < 2; m++)
    begin
      clean();
      pulse(cnt_wr);
      wait_on(STAT_STALE, 1'b0);
      wait_on(STAT_STALE, 1'b1);
      cycles(1);
      cmp_bit(1'b1, fsr[STAT_TIMEOUT]);
      cmp_bit(1'b1, pipe_int);
      to_en = 1'b0;
      err = 1'b1;
      cycles(1);
      cmp_bit(1'b0, pipe_int);
      err_en = 1'b1;
      cycles(1);
      cmp_bit(1'b1, pipe_int);
      err = 1'b0;
      err_en = 1'b0;
      to_en = 1'b1;
      if (m == 0)
        pulse(clr_to);
      else
        pulse(frst);
      cmp_bit(1'b0, fsr[STAT_TIMEOUT]);
    end
    sup = 1'b1;
    cycles(1);
    cmp_bit(1'b0, fsr[STAT_STALE]);
    sup = 1'b0;
    cycles(1);
    cmp_bit(1'b1, fsr[STAT_TIMEOUT]);
    clean();
    comp = 1'b0;
    repeat (4)
    begin
      lfsr = lfsr_next(lfsr);
      tx_word(lfsr[7:0], lfsr[15:8], 1'b1);
    end
    wait_on(9, 1'b1);
    for (int r = 0; r < 2; r++)
    begin
      clean();
      comp = 1'b1;
      lfsr = lfsr_next(lfsr);
      a = lfsr[7:0];
      tx_word(a, a, 1'b0);
      tx_word(a, a, 1'b0);
      tx_word(a, a ^ 8'h5A, 1'b0);
      exp_bytes = '{9'h103, {1'b0, a}, {1'b0, a}, {1'b0, a ^ 8'h5A}};
      cycles(80);
      cmp_byte(9'h002, 9'(exp_bytes.size()));
      if (r == 0)
        dma_en = 1'b0;
      else
        comp = 1'b0;
      wait_on(9, 1'b1);
      dma_en = 1'b1;
    end
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
